// [design/tws_pkg.sv]
// Notes on behaviour
// - Port is target only, never starts transfers.
// - Match address 01101, select pins, direction.
// - First byte LSB: one reads, zero writes.
// - Subaddress decodes word length: two, four or five bytes.
// - Step subaddress after each complete word.
// - Start: data falls while clock high.
// - Shift eight address bits, MSB first.
// - Matching address acknowledged on ninth clock.
// - Mismatch: release bus, return idle.
// - Stop: data rises while clock high.
// - Stray start: back to address phase; stray stop: back to idle.
// - Invalid subaddress: no acknowledge, idle.
// - Read past top repeats top location.
// - Write past top: discard, nack, idle.
// - Subaddress high byte, low byte, then data.
// - Port active only when boot pin low at its single capture after reset.
package tws_pkg;

	localparam logic [4:0]  DEV_ADDR_HI   = 5'h0D;
	localparam int          SYNC_W        = 5;
	localparam int          SI_SCL        = 0;
	localparam int          SI_SDA        = 1;
	localparam int          SI_BOOT       = 2;
	localparam int          SI_SEL_A      = 3;
	localparam int          SI_SEL_B      = 4;
	localparam logic [4:0]  SYNC_RESET    = 5'h07;
	localparam logic [1:0]  EN_CAPTURE    = 2'h3;
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [15:0] SUB_PARAM_END = 16'h03FF;
	localparam logic [15:0] SUB_PROG_END  = 16'h07FF;
	localparam logic [15:0] SUB_TOP       = 16'h081F;
	localparam logic [2:0]  LEN_PARAM     = 3'h4;
	localparam logic [2:0]  LEN_PROG      = 3'h5;
	localparam logic [2:0]  LEN_REG       = 3'h2;
	localparam logic [2:0]  LEN_NONE      = 3'h0;
	localparam logic [1:0]  PH_SUB_HI     = 2'h0;
	localparam logic [1:0]  PH_SUB_LO     = 2'h1;
	localparam logic [1:0]  PH_DATA       = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_MACK,
		ST_MNEXT
	} tws_state_e;

	// Word length of a subaddress, zero when unmapped
	function automatic logic [2:0] tws_word_len(input logic [15:0] sa);
		if (sa <= SUB_PARAM_END)
			return LEN_PARAM;
		else if (sa <= SUB_PROG_END)
			return LEN_PROG;
		else if (sa <= SUB_TOP)
			return LEN_REG;
		else
			return LEN_NONE;
	endfunction : tws_word_len

endpackage : tws_pkg

// [design/tws_slave.sv]
`timescale 1ns/10ps
module tws_slave
	import tws_pkg::*;
#(
	parameter int WORD_W = 40
)
(
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic              addr_select_pin_a,
	input  wire logic              addr_select_pin_b,
	input  wire logic              boot_source_select_pin,
	output logic                   port_active,
	output logic [15:0]            mem_addr,
	output logic [WORD_W-1:0]      mem_wdata,
	output logic                   mem_wr,
	output logic                   mem_rd,
	input  wire logic [WORD_W-1:0] mem_rdata,
	input  wire logic              mem_rvalid
);

	logic [SYNC_W-1:0] pins_s;
	logic              scl_s;
	logic              sda_s;
	logic              scl_q;
	logic              sda_q;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_det;
	logic              stop_det;
	logic [1:0]        en_cnt;
	tws_state_e        st;
	logic [3:0]        bit_cnt;
	logic [7:0]        shreg;
	logic [7:0]        txsh;
	logic              sda_drv;
	logic              rw;
	logic [1:0]        phase;
	logic [2:0]        bw;
	logic [2:0]        rb;
	logic [15:0]       sub_addr;
	logic              past_top;
	logic [31:0]       wbuf;
	logic [WORD_W-1:0] rword;
	logic              addr_hit;
	logic [2:0]        cur_len;
	logic [2:0]        lo_len;
	logic [15:0]       next_sub;
	logic [7:0]        next_tx;

	// Pick byte idx of a word of len bytes, MSB first
	function automatic logic [7:0] pick_byte(input logic [WORD_W-1:0] w,
		input logic [2:0] len, input logic [2:0] idx);
		int sh;
		sh = 8 * (int'(len) - 1 - int'(idx));
		if (sh < 0)
			sh = 0;
		return w[sh +: 8];
	endfunction : pick_byte

	tws_sync #(
		.W   (SYNC_W),
		.RST (SYNC_RESET)
	) u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.d       ({addr_select_pin_b, addr_select_pin_a, boot_source_select_pin,
			sda_in, scl_in}),
		.q       (pins_s)
	);

	assign scl_s = pins_s[SI_SCL];
	assign sda_s = pins_s[SI_SDA];

	// Line history for edge finding
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	// Mode capture once synchronisers settle
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			en_cnt      <= 2'h0;
			port_active <= 1'b0;
		end
		else if (en_cnt != EN_CAPTURE)
		begin
			en_cnt <= en_cnt + 2'h1;
			if (en_cnt + 2'h1 == EN_CAPTURE)
				port_active <= ~pins_s[SI_BOOT];
		end
	end

	assign addr_hit = (shreg[7:3] == DEV_ADDR_HI)
		&& (shreg[2] == pins_s[SI_SEL_A])
		&& (shreg[1] == pins_s[SI_SEL_B]);
	assign cur_len  = tws_word_len(sub_addr);
	assign lo_len   = tws_word_len({sub_addr[15:8], shreg});
	assign next_sub = (sub_addr == SUB_TOP) ? sub_addr : sub_addr + 16'h0001;
	assign next_tx  = pick_byte(rword, cur_len, rb);

	// Read word holding register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			rword <= '0;
		else if (mem_rvalid)
			rword <= mem_rdata;
	end

	// Bus protocol engine
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			st        <= ST_IDLE;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			txsh      <= 8'h00;
			sda_drv   <= 1'b0;
			rw        <= 1'b0;
			phase     <= PH_SUB_HI;
			bw        <= 3'h0;
			rb        <= 3'h0;
			sub_addr  <= 16'h0000;
			past_top  <= 1'b0;
			wbuf      <= 32'h0000_0000;
			mem_addr  <= 16'h0000;
			mem_wdata <= '0;
			mem_wr    <= 1'b0;
			mem_rd    <= 1'b0;
		end
		else
		begin
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
			if (!port_active)
			begin
				st      <= ST_IDLE;
				sda_drv <= 1'b0;
			end
			else if (stop_det)
			begin
				st      <= ST_IDLE;
				sda_drv <= 1'b0;
			end
			else if (start_det)
			begin
				st       <= ST_ADDR;
				bit_cnt  <= 4'h0;
				phase    <= PH_SUB_HI;
				past_top <= 1'b0;
				sda_drv  <= 1'b0;
			end
			else
			begin
				case (st)
					ST_ADDR,
					ST_RX:
					begin
						if (scl_rise && bit_cnt != BYTE_BITS)
						begin
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end
						else if (scl_fall && bit_cnt == BYTE_BITS)
						begin
							bit_cnt <= 4'h0;
							if (st == ST_ADDR)
							begin
								if (addr_hit)
								begin
									st      <= ST_ACK;
									sda_drv <= 1'b1;
									rw      <= shreg[0];
									rb      <= 3'h0;
									if (shreg[0])
									begin
										mem_rd   <= 1'b1;
										mem_addr <= sub_addr;
									end
								end
								else
									st <= ST_IDLE;
							end
							else
							begin
								case (phase)
									PH_SUB_HI:
									begin
										sub_addr[15:8] <= shreg;
										phase          <= PH_SUB_LO;
										st             <= ST_ACK;
										sda_drv        <= 1'b1;
									end
									PH_SUB_LO:
									begin
										if (lo_len == LEN_NONE)
											st <= ST_IDLE;
										else
										begin
											sub_addr[7:0] <= shreg;
											phase         <= PH_DATA;
											bw            <= 3'h0;
											st            <= ST_ACK;
											sda_drv       <= 1'b1;
										end
									end
									default:
									begin
										if (past_top)
											st <= ST_IDLE;
										else
										begin
											st      <= ST_ACK;
											sda_drv <= 1'b1;
											wbuf    <= (bw == 3'h0) ? {24'h0, shreg}
												: {wbuf[23:0], shreg};
											if (bw + 3'h1 == cur_len)
											begin
												mem_wr    <= 1'b1;
												mem_addr  <= sub_addr;
												mem_wdata <= (bw == 3'h0)
													? WORD_W'(shreg)
													: WORD_W'({wbuf, shreg});
												bw        <= 3'h0;
												if (sub_addr == SUB_TOP)
													past_top <= 1'b1;
												else
													sub_addr <= next_sub;
											end
											else
												bw <= bw + 3'h1;
										end
									end
								endcase
							end
						end
					end
					ST_ACK:
					begin
						if (scl_fall)
						begin
							bit_cnt <= 4'h0;
							if (rw)
							begin
								st      <= ST_TX;
								txsh    <= next_tx;
								sda_drv <= ~next_tx[7];
							end
							else
							begin
								st      <= ST_RX;
								sda_drv <= 1'b0;
							end
						end
					end
					ST_TX:
					begin
						if (scl_fall)
						begin
							if (bit_cnt == 4'h7)
							begin
								st      <= ST_MACK;
								sda_drv <= 1'b0;
								bit_cnt <= 4'h0;
							end
							else
							begin
								txsh    <= {txsh[6:0], 1'b0};
								sda_drv <= ~txsh[6];
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					ST_MACK:
					begin
						if (scl_rise)
						begin
							if (sda_s)
								st <= ST_IDLE;
							else
							begin
								st <= ST_MNEXT;
								if (rb + 3'h1 == cur_len)
								begin
									rb       <= 3'h0;
									sub_addr <= next_sub;
									mem_rd   <= 1'b1;
									mem_addr <= next_sub;
								end
								else
									rb <= rb + 3'h1;
							end
						end
					end
					ST_MNEXT:
					begin
						if (scl_fall)
						begin
							st      <= ST_TX;
							bit_cnt <= 4'h0;
							txsh    <= next_tx;
							sda_drv <= ~next_tx[7];
						end
					end
					default:
					begin
						st      <= ST_IDLE;
						sda_drv <= 1'b0;
					end
				endcase
			end
		end
	end

	// Open-drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = sda_drv;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	chk_idle_quiet:
	assert property (st == ST_IDLE |=> !sda_oe)
		else $error("Bus driven while idle");

	chk_start_addr:
	assert property (port_active && start_det && !stop_det |=> st == ST_ADDR && bit_cnt == 4'h0)
		else $error("Start not taken");

	chk_stop_idle:
	assert property (stop_det |=> st == ST_IDLE && !sda_oe)
		else $error("Stop did not end transfer");

	chk_addr_ack:
	assert property (st == ST_ADDR && scl_fall && bit_cnt == BYTE_BITS && addr_hit
		&& !start_det && !stop_det && port_active |=> st == ST_ACK && sda_oe)
		else $error("Matching address not acknowledged");

	chk_addr_miss:
	assert property (st == ST_ADDR && scl_fall && bit_cnt == BYTE_BITS && !addr_hit
		&& !start_det && !stop_det |=> st == ST_IDLE && !sda_oe)
		else $error("Foreign address not released");

	chk_bad_sub:
	assert property (st == ST_RX && phase == PH_SUB_LO && scl_fall && bit_cnt == BYTE_BITS
		&& lo_len == LEN_NONE && !start_det && !stop_det |=> st == ST_IDLE && !sda_oe)
		else $error("Invalid subaddress acknowledged");

	chk_wr_step:
	assert property (mem_wr && mem_addr != SUB_TOP |-> sub_addr == mem_addr + 16'h0001)
		else $error("Subaddress not stepped after word");

	chk_wr_over:
	assert property (st == ST_RX && phase == PH_DATA && past_top && scl_fall
		&& bit_cnt == BYTE_BITS && !start_det && !stop_det |=> st == ST_IDLE && !mem_wr)
		else $error("Overflow byte accepted");

	chk_top_hold:
	assert property (mem_rd |-> mem_addr <= SUB_TOP)
		else $error("Read subaddress past top");

	chk_mode_off:
	assert property (!port_active |=> st == ST_IDLE ##1 !sda_oe)
		else $error("Port active in wrong mode");

	chk_word_len:
	assert property ($rose(mem_wr) |-> $past(bw) + 3'h1 == $past(cur_len))
		else $error("Word length mismatch");

endmodule : tws_slave

// [design/tws_sync.sv]
`timescale 1ns/10ps
module tws_sync
	import tws_pkg::*;
#(
	parameter int         W   = SYNC_W,
	parameter logic [W-1:0] RST = SYNC_RESET
)
(
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// Two flops per pin
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			meta <= RST;
			q    <= RST;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : tws_sync

// [verif/tws_master_model.sv]
`timescale 1ns/10ps
module tws_master_model
(
	input  wire logic ref_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// Both lines released, pulled high, clock still outside frames
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic hw(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : hw

	// Start or repeated start, one condition per clock high
	task automatic start();
		sda_low <= 1'b0;
		hw(2);
		scl <= 1'b1;
		hw(2);
		sda_low <= 1'b1;
		hw(2);
		scl <= 1'b0;
		hw(2);
	endtask : start

	// Stop closes a transfer; some transfers end in a repeated start instead
	task automatic stop();
		sda_low <= 1'b1;
		hw(2);
		scl <= 1'b1;
		hw(2);
		sda_low <= 1'b0;
		hw(4);
	endtask : stop

	// One bit, data set while clock low, sampled mid high
	task automatic clk_bit(input logic b, output logic r);
		sda_low <= ~b;
		hw(2);
		scl <= 1'b1;
		hw(2);
		r = sda;
		hw(2);
		scl <= 1'b0;
		hw(2);
	endtask : clk_bit

	// Byte out MSB first, ack read back
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], r);
		clk_bit(1'b1, r);
		ack = ~r;
	endtask : wbyte

	// Byte in, master ack or nack to end the read
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(~mack, r);
	endtask : rbyte
endmodule : tws_master_model

// [verif/tws_slave_tb.sv]
`timescale 1ns/10ps
module tws_slave_tb;
	import tws_pkg::*;
	logic        ref_clk, reset, scl, m_low, pin_a, pin_b, boot, ack;
	logic        sda_out, sda_oe, port_active, mem_wr, mem_rd;
	logic        rvalid = 1'b0;
	logic [15:0] mem_addr, sa;
	logic [39:0] mem_wdata, w;
	logic [39:0] rdata = 40'h0;
	logic [55:0] wq[$];
	logic [7:0]  d;
	int          seed = 56213, n_fail = 0, cmp_count = 0, cyc = 0, n;
	wire logic   sda = ~(m_low | (sda_oe & ~sda_out));

	tws_slave i_tws_slave(.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_a(pin_a),
		.addr_select_pin_b(pin_b), .boot_source_select_pin(boot),
		.port_active(port_active), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(rdata), .mem_rvalid(rvalid));
	tws_master_model i_tws_master_model(.ref_clk(ref_clk), .sda(sda), .scl(scl),
		.sda_low(m_low));

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	function automatic logic [39:0] pat(input logic [15:0] a);
		return {a, ~a, 8'h5A};
	endfunction : pat

	function automatic int lenof(input logic [15:0] a);
		return (a < 16'h0400) ? 4 : (a < 16'h0800) ? 5 : 2;
	endfunction : lenof

	function automatic logic [7:0] adr(input logic rw);
		return {DEV_ADDR_HI, pin_a, pin_b, rw};
	endfunction : adr

	// Memory stand-in: answers next cycle, since the next byte leaves within a few cycles
	always @(posedge ref_clk)
	begin
		cyc    <= cyc + 1;
		rvalid <= mem_rd;
		rdata  <= mem_rd ? pat(mem_addr) : ~rdata;
		if (mem_wr)
			wq.push_back({mem_addr, mem_wdata});
		if (cyc == 40000)
		begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [55:0] e, input logic [55:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic send(input logic [7:0] b, input logic e);
		i_tws_master_model.wbyte(b, ack);
		chk("ack", 56'(e), 56'(ack));
	endtask : send

	task automatic hdr(input logic [15:0] a);
		i_tws_master_model.start();
		send(adr(1'b0), 1'b1);
		send(a[15:8], 1'b1);
		send(a[7:0], 1'b1);
	endtask : hdr

	task automatic rd(input logic [15:0] a0, input int nw);
		logic [15:0] a;
		int          l;
		l = lenof(a0);
		hdr(a0);
		i_tws_master_model.start();
		send(adr(1'b1), 1'b1);
		for (int k = 0; k < nw * l; k++)
		begin
			a = (a0 + 16'(k / l) > SUB_TOP) ? SUB_TOP : a0 + 16'(k / l);
			i_tws_master_model.rbyte(k < nw * l - 1, d);
			w = pat(a);
			chk("read byte", 56'(w[8 * (l - 1 - k % l) +: 8]), 56'(d));
		end
		i_tws_master_model.stop();
	endtask : rd

	initial
	begin
		reset = 1'b1;
		boot = 1'b0;
		{pin_a, pin_b} = 2'($random(seed));
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk("port_active", 56'h1, 56'(port_active));
		for (int i = 0; i < 4; i++)
		begin
			{pin_a, pin_b} <= 2'(i);
			repeat (4) @(posedge ref_clk);
			sa = (i % 3 == 2) ? 16'h0800 + 16'($unsigned($random(seed)) % 30) :
				16'((i % 3) * 16'h0400) + 16'($unsigned($random(seed)) % 1022);
			n = lenof(sa);
			wq.delete();
			hdr(sa);
			for (int j = 0; j < 2; j++)
			begin
				w = 40'({$random(seed), $random(seed)});
				w = w & ~(40'hFFFFFFFFFF << (8 * n));
				for (int k = n - 1; k >= 0; k--)
					send(w[8 * k +: 8], 1'b1);
				chk("write", {sa + 16'(j), w}, (wq.size() > 0) ? wq.pop_front() : 56'hX);
			end
			i_tws_master_model.stop();
			i_tws_master_model.start();
			send({DEV_ADDR_HI, ~pin_a, pin_b, 1'b0}, 1'b0);
			i_tws_master_model.stop();
			rd(sa, 2);
		end
		rd(SUB_TOP, 2);
		hdr(SUB_TOP);
		send(8'h12, 1'b1);
		send(8'h34, 1'b1);
		send(8'h56, 1'b0);
		i_tws_master_model.stop();
		chk("top write", {SUB_TOP, 40'h1234}, (wq.size() > 0) ? wq.pop_front() : 56'hX);
		i_tws_master_model.start();
		send(adr(1'b0), 1'b1);
		send(8'h08, 1'b1);
		send(8'h20, 1'b0);
		i_tws_master_model.stop();
		hdr(16'h0000);
		for (int k = 0; k < 3; k++)
			i_tws_master_model.clk_bit(1'b0, ack);
		i_tws_master_model.start();
		send(adr(1'b0), 1'b1);
		i_tws_master_model.stop();
		chk("write count", 56'h0, 56'(wq.size()));
		reset <= 1'b1;
		boot <= 1'b1;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk("port_active", 56'h0, 56'(port_active));
		i_tws_master_model.start();
		send(adr(1'b0), 1'b0);
		i_tws_master_model.stop();
		wrap_up();
	end
endmodule : tws_slave_tb
